// file: hw/fcfl_flags.sv
/*
 fcfl_flags: address counters and full, empty, almost-full and
 almost-empty flags of a fifo, with halt controls on both counters.
 assumes: write and read user logic run on CLOCK_I; storage array sits
 outside and uses the pointers as addresses; depth is a power of two.
*/
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - empty halt high and empty set: read counter stops advancing.
// - full halt high and full set: write counter stops advancing.
// - full flag rises when nothing more can be written; write side.
// - full blocks further writes at once; no overflow while full halt is high.
// - full compares against synchronised read pointer; clears two edges late.
// - empty flag rises when nothing more can be read; read side.
// - empty blocks further reads at once; no underflow while empty halt is high.
// - empty compares against synchronised write pointer; clears two edges late.
// - independent 12-bit write and read counters, plus one per operation.
// - counters start at zero, reach depth minus one, wrap to zero.
// - almost-full high while write minus read reaches the threshold.
// - almost-empty high while write minus read is at most threshold.
// - thresholds count data bits, not words.
// - almost-full stays high until difference falls below threshold.
// - empty halt low: read counter runs past empty and wraps.
module fcfl_flags
   import fcfl_pkg::*;
#(
   parameter int DEPTH_LOG2 = DEF_DEPTH_LOG2,
   parameter int WORD_BITS = DEF_WORD_BITS
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic WRITE_REQ_I,
   input wire logic READ_REQ_I,
   input wire logic FULL_HALT_I,
   input wire logic EMPTY_HALT_I,
   input wire logic [THR_W-1:0] ALMOST_FULL_THRESHOLD_I,
   input wire logic [THR_W-1:0] ALMOST_EMPTY_THRESHOLD_I,
   output logic [PTR_W-1:0] WRITE_POINTER_O,
   output logic [PTR_W-1:0] READ_POINTER_O,
   output logic WRITE_ACCEPT_O,
   output logic READ_ACCEPT_O,
   output logic FULL_O,
   output logic EMPTY_O,
   output logic ALMOST_FULL_O,
   output logic ALMOST_EMPTY_O
);
   // one extra wrap bit tells full from empty
   localparam int PW = DEPTH_LOG2 + 1;
   localparam logic [BITCNT_W-1:0] WORD_BITS_C = BITCNT_W'(WORD_BITS);

   // write side state
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] wr_ptr_d;
   logic [PW-1:0] wr_gray_q;
   logic full_q;
   logic full_d;
   logic almost_full_flag_q;
   logic almost_full_flag_d;
   logic wr_accept_q;

   // read side state
   logic [PW-1:0] rd_ptr_q;
   logic [PW-1:0] rd_ptr_d;
   logic [PW-1:0] rd_gray_q;
   logic empty_q;
   logic empty_d;
   logic almost_empty_flag_q;
   logic almost_empty_flag_d;
   logic rd_accept_q;

   // pointer crossings
   fcfl_ptr_if #(.W(PW)) wr_xing ();
   fcfl_ptr_if #(.W(PW)) rd_xing ();

   fcfl_gray_sync #(
      .W(PW)
   ) u_wr_to_rd (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .ptr(wr_xing.catch)
   );

   fcfl_gray_sync #(
      .W(PW)
   ) u_rd_to_wr (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .ptr(rd_xing.catch)
   );

   assign wr_xing.gray = wr_gray_q;
   assign rd_xing.gray = rd_gray_q;

   // write side decode
   wire [PW-1:0] rd_seen_w = rd_xing.bin;
   wire wr_take = WRITE_REQ_I && !full_q;
   wire wr_halted = FULL_HALT_I && full_q;
   wire wr_step = WRITE_REQ_I && !wr_halted;
   wire [PW-1:0] wr_full_mark = {~rd_seen_w[PW-1], rd_seen_w[PW-2:0]};
   wire [PW-1:0] wr_fill_words = wr_ptr_d - rd_seen_w;
   wire [BITCNT_W-1:0] wr_fill_bits = BITCNT_W'(BITCNT_W'(wr_fill_words) * WORD_BITS_C);
   wire [BITCNT_W-1:0] almost_full_flag_thr = BITCNT_W'(ALMOST_FULL_THRESHOLD_I);

   // counter wraps naturally at the power-of-two depth
   assign wr_ptr_d = wr_step ? PW'(wr_ptr_q + 1'b1) : wr_ptr_q;
   assign full_d = (wr_ptr_d == wr_full_mark);
   assign almost_full_flag_d = (wr_fill_bits >= almost_full_flag_thr);
   // level compare holds the flag until the fill drops below threshold

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         wr_ptr_q <= '0;
         wr_gray_q <= '0;
         full_q <= FULL_RST;
         almost_full_flag_q <= ALMOST_FULL_FLAG_RST;
         wr_accept_q <= 1'b0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         wr_gray_q <= wr_ptr_d ^ (wr_ptr_d >> 1);
         full_q <= full_d;
         almost_full_flag_q <= almost_full_flag_d;
         wr_accept_q <= wr_take;
      end
   end

   // read side decode
   wire [PW-1:0] wr_seen_w = wr_xing.bin;
   wire rd_take = READ_REQ_I && !empty_q;
   wire rd_halted = EMPTY_HALT_I && empty_q;
   // halt low lets the counter run past empty for repeated reads
   wire rd_step = READ_REQ_I && !rd_halted;
   wire [PW-1:0] rd_fill_words = wr_seen_w - rd_ptr_d;
   wire [BITCNT_W-1:0] rd_fill_bits = BITCNT_W'(BITCNT_W'(rd_fill_words) * WORD_BITS_C);
   wire [BITCNT_W-1:0] almost_empty_flag_thr = BITCNT_W'(ALMOST_EMPTY_THRESHOLD_I);

   assign rd_ptr_d = rd_step ? PW'(rd_ptr_q + 1'b1) : rd_ptr_q;
   assign empty_d = (rd_ptr_d == wr_seen_w);
   assign almost_empty_flag_d = (rd_fill_bits <= almost_empty_flag_thr);

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         rd_ptr_q <= '0;
         rd_gray_q <= '0;
         empty_q <= EMPTY_RST;
         almost_empty_flag_q <= ALMOST_EMPTY_FLAG_RST;
         rd_accept_q <= 1'b0;
      end else begin
         rd_ptr_q <= rd_ptr_d;
         rd_gray_q <= rd_ptr_d ^ (rd_ptr_d >> 1);
         empty_q <= empty_d;
         almost_empty_flag_q <= almost_empty_flag_d;
         rd_accept_q <= rd_take;
      end
   end

   // wrap bit dropped; the upper address bits read as zero
   assign WRITE_POINTER_O = PTR_W'(wr_ptr_q[PW-2:0]);
   assign READ_POINTER_O = PTR_W'(rd_ptr_q[PW-2:0]);
   assign WRITE_ACCEPT_O = wr_accept_q;
   assign READ_ACCEPT_O = rd_accept_q;
   assign FULL_O = full_q;
   assign EMPTY_O = empty_q;
   assign ALMOST_FULL_O = almost_full_flag_q;
   assign ALMOST_EMPTY_O = almost_empty_flag_q;
endmodule // fcfl_flags
`default_nettype wire

// file: hw/fcfl_gray_sync.sv
/*
 fcfl_gray_sync: two-stage synchroniser for a gray pointer, with
 gray to binary decode after the second stage.
 assumes: single clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module fcfl_gray_sync
   import fcfl_pkg::*;
#(
   parameter int W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   fcfl_ptr_if.catch ptr
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;
   logic [W-1:0] bin;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= ptr.gray;
         stage2_q <= stage1_q;
      end
   end

   always_comb begin
      bin[W-1] = stage2_q[W-1];
      for (int i = W - 2; i >= 0; i--) begin
         bin[i] = bin[i+1] ^ stage2_q[i];
      end
   end

   assign ptr.bin = bin;
endmodule // fcfl_gray_sync
`default_nettype wire

// file: hw/fcfl_pkg.sv
/*
 fcfl_pkg: shared constants of the fifo flag and counter logic.
 assumes: imported whole by every fifo flag module.
*/
`default_nettype none
package fcfl_pkg;
   // widths of the address counters and threshold inputs
   localparam int PTR_W = 12;
   localparam int THR_W = 12;
   // width of the bit-count arithmetic; holds depth times word width
   localparam int BITCNT_W = 16;
   // default geometry: 512 words of 9 bits
   localparam int DEF_DEPTH_LOG2 = 9;
   localparam int DEF_WORD_BITS = 9;
   // synchroniser length between the write and read sides
   localparam int SYNC_STAGES = 2;
   // reset values
   localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
   localparam logic FULL_RST = 1'b0;
   localparam logic EMPTY_RST = 1'b1;
   localparam logic ALMOST_FULL_FLAG_RST = 1'b0;
   localparam logic ALMOST_EMPTY_FLAG_RST = 1'b1;
endpackage
`default_nettype wire

// file: hw/fcfl_ptr_if.sv
/*
 fcfl_ptr_if: carries one gray-coded pointer into the other side and
 its synchronised binary copy back.
 assumes: launch side drives gray from a flip-flop.
*/
`timescale 1ns/10ps
`default_nettype none
interface fcfl_ptr_if #(
   parameter int W = 10
);
   logic [W-1:0] gray;
   logic [W-1:0] bin;
   modport launch (
      output gray,
      input bin
   );
   modport catch (
      input gray,
      output bin
   );
endinterface
`default_nettype wire

// file: test/dual_clock_fifo_flag_logic_test.sv
/*
 dual_clock_fifo_flag_logic_test: fills, drains and rereads a four-word fifo.
 assumes: fcfl_user drives the request ports, checker bound to the design.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_clock_fifo_flag_logic_test;
   import fcfl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wgo = 1'b0, rgo = 1'b0, fh = 1'b1, eh = 1'b1;
   logic wreq, rreq, wacc, racc, full, empty, af, ae;
   logic [THR_W-1:0] aft, aet;
   logic [PTR_W-1:0] wp, rp;
   int err_total = 0;
   int compares = 0;
   initial forever #4 clk = ~clk;
   fcfl_user usr (.clk_i(clk), .wr_go_i(wgo), .rd_go_i(rgo), .wr_req_o(wreq), .rd_req_o(rreq),
      .af_thr_o(aft), .ae_thr_o(aet));
   // depth of four words keeps wrap and full within a few cycles
   fcfl_flags #(.DEPTH_LOG2(2), .WORD_BITS(9)) uut (.CLOCK_I(clk), .RST_I(rst),
      .WRITE_REQ_I(wreq), .READ_REQ_I(rreq), .FULL_HALT_I(fh), .EMPTY_HALT_I(eh),
      .ALMOST_FULL_THRESHOLD_I(aft), .ALMOST_EMPTY_THRESHOLD_I(aet), .WRITE_POINTER_O(wp),
      .READ_POINTER_O(rp), .WRITE_ACCEPT_O(wacc), .READ_ACCEPT_O(racc), .FULL_O(full),
      .EMPTY_O(empty), .ALMOST_FULL_O(af), .ALMOST_EMPTY_O(ae));
   task chk(input logic [PTR_W-1:0] got, input logic [PTR_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // n back-to-back requests, then time for the synchronisers to settle
   task run(input int n, input logic wr);
      @(posedge clk);
      if (wr) wgo <= 1'b1;
      else rgo <= 1'b1;
      repeat (n) @(posedge clk);
      wgo <= 1'b0;
      rgo <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      give_verdict;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(wp | rp, PTR_RST);
      chk(PTR_W'({full, empty, af, ae}), 12'h005);
      $display("reset test done");
      run(6, 1'b1);
      chk(wp, 12'h000);
      chk(PTR_W'({full, empty, af, ae}), 12'h00A);
      $display("fill test done");
      run(1, 1'b0);
      chk(PTR_W'({full, empty, af, ae}), 12'h002);
      run(2, 1'b0);
      chk(PTR_W'({full, empty, af, ae}), 12'h001);
      run(3, 1'b0);
      chk(rp, 12'h000);
      chk(PTR_W'({full, empty, af, ae}), 12'h005);
      $display("drain test done");
      // halt input changes on the edge like every other stimulus
      @(posedge clk);
      eh <= 1'b0;
      run(1, 1'b0);
      chk(rp, 12'h001);
      $display("reread test done");
      // reset again from a non-zero read pointer, three edges long
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(wp | rp, PTR_RST);
      chk(PTR_W'({full, empty, af, ae}), 12'h005);
      $display("second reset test done");
      give_verdict;
   end
endmodule // dual_clock_fifo_flag_logic_test
`default_nettype wire

// file: test/fcfl_flags_properties.sv
/*
 fcfl_flags_properties: port-level checks of the fifo flag logic.
 assumes: bound into every fcfl_flags instance, single clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fcfl_flags_properties
   import fcfl_pkg::*;
#(
   parameter int DEPTH_LOG2 = DEF_DEPTH_LOG2
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic WRITE_REQ_I,
   input wire logic READ_REQ_I,
   input wire logic FULL_HALT_I,
   input wire logic EMPTY_HALT_I,
   input wire logic [PTR_W-1:0] WRITE_POINTER_O,
   input wire logic [PTR_W-1:0] READ_POINTER_O,
   input wire logic WRITE_ACCEPT_O,
   input wire logic READ_ACCEPT_O,
   input wire logic FULL_O,
   input wire logic EMPTY_O
);
   localparam logic [PTR_W-1:0] MASK = PTR_W'((1 << DEPTH_LOG2) - 1);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   // quiet spell first, so no earlier write is still in the synchroniser
   sequence quiet_s; (!WRITE_REQ_I && !READ_REQ_I) [*3]; endsequence
   sequence fill_s; EMPTY_O && WRITE_REQ_I && !READ_REQ_I ##1 !READ_REQ_I [*3]; endsequence
   sequence drain_s; FULL_O && READ_REQ_I && !WRITE_REQ_I ##1 !WRITE_REQ_I [*3]; endsequence
   a_wr_accept: assert property (WRITE_REQ_I && !FULL_O |=> WRITE_ACCEPT_O)
      else $error("write not accepted");
   a_wr_block: assert property (WRITE_REQ_I && FULL_O |=> !WRITE_ACCEPT_O)
      else $error("write accepted while full");
   a_rd_accept: assert property (READ_REQ_I && !EMPTY_O |=> READ_ACCEPT_O)
      else $error("read not accepted");
   a_rd_block: assert property (READ_REQ_I && EMPTY_O |=> !READ_ACCEPT_O)
      else $error("read accepted while empty");
   a_wr_halt: assert property (FULL_HALT_I && FULL_O |=> $stable(WRITE_POINTER_O))
      else $error("write pointer moved while halted");
   a_rd_halt: assert property (EMPTY_HALT_I && EMPTY_O |=> $stable(READ_POINTER_O))
      else $error("read pointer moved while halted");
   a_wr_step: assert property (WRITE_REQ_I && !(FULL_HALT_I && FULL_O) |=>
      WRITE_POINTER_O == (($past(WRITE_POINTER_O) + 12'h001) & MASK)) else $error("bad step");
   a_empty_late: assert property (quiet_s ##1 fill_s |-> EMPTY_O ##1 !EMPTY_O)
      else $error("empty cleared at wrong edge");
   // read side copy lags, so full only drops on the third edge
   a_full_late: assert property (quiet_s ##1 drain_s |-> FULL_O ##1 !FULL_O)
      else $error("full cleared at wrong edge");
   a_rd_step: assert property (READ_REQ_I && !(EMPTY_HALT_I && EMPTY_O) |=>
      READ_POINTER_O == (($past(READ_POINTER_O) + 12'h001) & MASK))
      else $error("bad read step");
endmodule // fcfl_flags_properties
bind fcfl_flags fcfl_flags_properties #(.DEPTH_LOG2(DEPTH_LOG2)) u_props (.*);
`default_nettype wire

// file: test/fcfl_user.sv
/*
 fcfl_user: user logic at the fifo write and read ports.
 assumes: bench steers it with go levels on the fifo clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fcfl_user
   import fcfl_pkg::*;
(
   input wire logic clk_i,
   input wire logic wr_go_i,
   input wire logic rd_go_i,
   output logic wr_req_o = 1'b0,
   output logic rd_req_o = 1'b0,
   output logic [THR_W-1:0] af_thr_o,
   output logic [THR_W-1:0] ae_thr_o
);
   // thresholds in bits: three words and one word of nine bits
   assign af_thr_o = 12'h01B;
   assign ae_thr_o = 12'h009;
   // registered, so requests only change just after an edge
   always @(posedge clk_i) begin
      wr_req_o <= wr_go_i;
      rd_req_o <= rd_go_i;
   end
endmodule // fcfl_user
`default_nettype wire
